// File: verilog/output_channel_divider_ctl.sv
// Channel 5 and 6 output divider, source mux and driver control with AXI4-Lite registers
// Contract
// - Divider ratio is the 8-bit code plus one, 1 to 256
// - Divider acts only for a PLL source; reference sources bypass it
// - Channel 5 code resets to 0x02, channel 6 code to 0x05
// - Source select bits 7:6 pick PLL1, PLL2, primary, secondary; reset 0
// - Format bits 5:4 pick off, AC differential, HCSL, LVCMOS; reset 1
// - Mode1 bits 3:2 set tail current or CMOS positive leg; reset 2
// - Mode2 bits 1:0 set HCSL load or CMOS negative leg; reset 0
//
// Register access over AXI4-Lite is this design's own decision.
module output_channel_divider_ctl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic pll1_tick,
  input wire logic pll2_tick,
  input wire logic ref_pri_tick,
  input wire logic ref_sec_tick,
  input wire logic ch5_src_tick,
  input wire logic ch5_src_is_pll,
  output logic ch5_out_tick,
  output logic ch6_out_tick,
  output logic ch6_diff_en,
  output logic [1:0] ch6_format,
  output logic [1:0] ch6_tail_code,
  output logic [1:0] ch6_load_code,
  output logic ch6_p_level,
  output logic ch6_p_oe,
  output logic ch6_n_level,
  output logic ch6_n_oe
);

  // ==========================================================================
  // Registers
  logic [7:0] channel5_divide_ratio;
  logic [7:0] channel6_divide_ratio;
  logic [1:0] ch6_source_select;
  logic [1:0] ch6_format_select;
  logic [1:0] ch6_driver_mode_first;
  logic [1:0] ch6_driver_mode_second;
  wire logic [7:0] channel6_output_control = {ch6_source_select, ch6_format_select,
    ch6_driver_mode_first, ch6_driver_mode_second};

  // ==========================================================================
  // Write channel: address and data taken in either order
  outdiv_pkg::wr_state_t wr_state;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign awready = (wr_state == outdiv_pkg::WR_IDLE) || (wr_state == outdiv_pkg::WR_DATA);
  assign wready = (wr_state == outdiv_pkg::WR_IDLE) || (wr_state == outdiv_pkg::WR_ADDR);
  assign bvalid = (wr_state == outdiv_pkg::WR_RESP);

  wire logic aw_fire = awvalid && awready;
  wire logic w_fire = wvalid && wready;
  wire logic wr_commit = (wr_state == outdiv_pkg::WR_IDLE && aw_fire && w_fire)
    || (wr_state == outdiv_pkg::WR_ADDR && w_fire)
    || (wr_state == outdiv_pkg::WR_DATA && aw_fire);
  wire logic [7:0] wr_addr = aw_fire ? awaddr : aw_addr_q;
  wire logic [31:0] wr_data = w_fire ? wdata : w_data_q;
  wire logic [3:0] wr_strb = w_fire ? wstrb : w_strb_q;
  wire logic wr_ok = outdiv_pkg::addr_mapped(wr_addr);
  wire logic [7:0] wr_idx = outdiv_pkg::addr_index(wr_addr);
  // Status is read-only; only the low byte lane carries register bits
  wire logic wr_en = wr_commit && wr_ok && wr_strb[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state <= outdiv_pkg::WR_IDLE;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp <= outdiv_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) aw_addr_q <= awaddr;
      if (w_fire) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_commit) bresp <= wr_ok ? outdiv_pkg::RESP_OKAY : outdiv_pkg::RESP_SLVERR;
      case (wr_state)
        outdiv_pkg::WR_IDLE: begin
          if (wr_commit) wr_state <= outdiv_pkg::WR_RESP;
          else if (aw_fire) wr_state <= outdiv_pkg::WR_ADDR;
          else if (w_fire) wr_state <= outdiv_pkg::WR_DATA;
        end
        outdiv_pkg::WR_ADDR: if (w_fire) wr_state <= outdiv_pkg::WR_RESP;
        outdiv_pkg::WR_DATA: if (aw_fire) wr_state <= outdiv_pkg::WR_RESP;
        outdiv_pkg::WR_RESP: if (bready) wr_state <= outdiv_pkg::WR_IDLE;
        default: wr_state <= outdiv_pkg::WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel5_divide_ratio <= outdiv_pkg::RST_CH5_DIV;
      channel6_divide_ratio <= outdiv_pkg::RST_CH6_DIV;
      ch6_source_select <= outdiv_pkg::RST_CH6_SRC;
      ch6_format_select <= outdiv_pkg::RST_CH6_FMT;
      ch6_driver_mode_first <= outdiv_pkg::RST_CH6_MODE1;
      ch6_driver_mode_second <= outdiv_pkg::RST_CH6_MODE2;
    end else if (wr_en) begin
      if (wr_idx == outdiv_pkg::IDX_CH5_DIV) channel5_divide_ratio <= wr_data[7:0];
      if (wr_idx == outdiv_pkg::IDX_CH6_DIV) channel6_divide_ratio <= wr_data[7:0];
      if (wr_idx == outdiv_pkg::IDX_CH6_CTL) begin
        ch6_source_select <= wr_data[outdiv_pkg::SRC_LSB +: 2];
        ch6_format_select <= wr_data[outdiv_pkg::FMT_LSB +: 2];
        ch6_driver_mode_first <= wr_data[outdiv_pkg::MODE1_LSB +: 2];
        ch6_driver_mode_second <= wr_data[outdiv_pkg::MODE2_LSB +: 2];
      end
    end
  end

  // ==========================================================================
  // Channel datapath
  logic ch6_phase;
  logic div5_tick;
  logic div6_tick;
  wire logic ch6_src_is_pll = !ch6_source_select[1];
  wire logic ch6_on = (ch6_format_select != outdiv_pkg::FMT_OFF);
  wire logic ch6_cmos = (ch6_format_select == outdiv_pkg::FMT_CMOS);
  wire logic ch6_sel_tick = (ch6_source_select == outdiv_pkg::SRC_PLL1) ? pll1_tick :
    (ch6_source_select == outdiv_pkg::SRC_PLL2) ? pll2_tick :
    (ch6_source_select == outdiv_pkg::SRC_PRI_REF) ? ref_pri_tick : ref_sec_tick;
  wire logic [1:0] next_p_drive = ch6_cmos ?
    outdiv_pkg::leg_drive(ch6_driver_mode_first, ch6_phase) : 2'b00;
  wire logic [1:0] next_n_drive = ch6_cmos ?
    outdiv_pkg::leg_drive(ch6_driver_mode_second, ch6_phase) : 2'b00;

  chan_divider #(.WIDTH(8)) u_div5 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .src_tick(ch5_src_tick),
    .ratio_code(channel5_divide_ratio),
    .bypass(!ch5_src_is_pll),
    .div_tick(div5_tick)
  );

  chan_divider #(.WIDTH(8)) u_div6 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .src_tick(ch6_sel_tick),
    .ratio_code(channel6_divide_ratio),
    .bypass(!ch6_src_is_pll),
    .div_tick(div6_tick)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch6_phase <= 1'b0;
      ch5_out_tick <= 1'b0;
      ch6_out_tick <= 1'b0;
      ch6_diff_en <= 1'b0;
      ch6_format <= 2'h0;
      ch6_tail_code <= 2'h0;
      ch6_load_code <= 2'h0;
      {ch6_p_oe, ch6_p_level} <= 2'b00;
      {ch6_n_oe, ch6_n_level} <= 2'b00;
    end else begin
      // Phase parks low while off so a re-enable starts from a known edge
      ch6_phase <= ch6_on && (ch6_phase ^ div6_tick);
      ch5_out_tick <= div5_tick;
      ch6_out_tick <= div6_tick && ch6_on;
      ch6_diff_en <= ch6_on && !ch6_cmos;
      ch6_format <= ch6_format_select;
      ch6_tail_code <= ch6_on ? ch6_driver_mode_first : 2'h0;
      ch6_load_code <= ch6_on ? ch6_driver_mode_second : 2'h0;
      {ch6_p_oe, ch6_p_level} <= next_p_drive;
      {ch6_n_oe, ch6_n_level} <= next_n_drive;
    end
  end

  // ==========================================================================
  // Read channel: one cycle from address to data
  wire logic [7:0] rd_idx = outdiv_pkg::addr_index(araddr);
  wire logic [7:0] rd_byte = (rd_idx == outdiv_pkg::IDX_CH5_DIV) ? channel5_divide_ratio :
    (rd_idx == outdiv_pkg::IDX_CH6_CTL) ? channel6_output_control :
    (rd_idx == outdiv_pkg::IDX_CH6_DIV) ? channel6_divide_ratio :
    {5'h00, ch6_phase, ch6_on, ch6_src_is_pll};
  assign arready = !rvalid;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= outdiv_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= outdiv_pkg::addr_mapped(araddr) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      rresp <= outdiv_pkg::addr_mapped(araddr) ? outdiv_pkg::RESP_OKAY : outdiv_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic first_cycle;
  logic [8:0] seen5;
  logic seen5_ok;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_cycle <= 1'b1;
      seen5 <= 9'h000;
      seen5_ok <= 1'b0;
    end else begin
      first_cycle <= 1'b0;
      seen5 <= (div5_tick ? 9'h000 : seen5) + {8'h00, ch5_src_tick};
      seen5_ok <= (div5_tick || seen5_ok) && !wr_commit && ch5_src_is_pll;
    end
  end

  chk_div_ratio: assert property (div5_tick && seen5_ok |->
    seen5 == {1'b0, channel5_divide_ratio} + 9'h001) else $error("ch5 ratio wrong");
  chk_ref_bypass: assert property (!ch6_src_is_pll && ch6_on && ch6_sel_tick
    |-> ##2 ch6_out_tick) else $error("reference not bypassed");
  chk_reset_codes: assert property (first_cycle |-> channel5_divide_ratio == 8'h02
    && channel6_divide_ratio == 8'h05) else $error("divider reset codes wrong");
  // Watches the divider, not the mux: a quiet selected PLL2 source must stay quiet
  chk_source_route: assert property (ch6_source_select == outdiv_pkg::SRC_PLL2 && !pll2_tick
    |=> !div6_tick) else $error("source mux wrong");
  chk_ctl_reset: assert property (first_cycle |-> channel6_output_control == 8'h18)
    else $error("control reset wrong");
  chk_pos_leg: assert property (ch6_cmos && ch6_driver_mode_first == 2'h3
    && $stable(ch6_format_select) |=> ch6_p_oe && ch6_p_level == $past(ch6_phase))
    else $error("positive leg wrong");
  chk_neg_leg: assert property (ch6_cmos && ch6_driver_mode_second == 2'h0
    |=> !ch6_n_oe) else $error("negative leg not tristate");
  chk_off_quiet: assert property (!ch6_on [*2] |-> !ch6_out_tick && !ch6_p_oe && !ch6_n_oe
    && !ch6_diff_en) else $error("disabled output active");

  cov_ref_bypass: cover property (!ch6_src_is_pll && ch6_on ##2 ch6_out_tick);
  cov_cmos_drive: cover property (ch6_p_oe && ch6_n_oe);
  cov_write_done: cover property (bvalid && bready && bresp == outdiv_pkg::RESP_OKAY);
  cov_max_ratio: cover property (div5_tick && seen5_ok && channel5_divide_ratio == 8'hff);

endmodule

// File: verilog/outdiv_pkg.sv
// Shared constants, types and helpers for the output channel divider control block
package outdiv_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CH5_DIV = 8'h28;
  localparam logic [7:0] IDX_CH6_CTL = 8'h29;
  localparam logic [7:0] IDX_CH6_DIV = 8'h2a;
  localparam logic [7:0] IDX_STATUS = 8'h2b;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] RST_CH5_DIV = 8'h02;
  localparam logic [7:0] RST_CH6_DIV = 8'h05;
  localparam logic [1:0] RST_CH6_SRC = 2'h0;
  localparam logic [1:0] RST_CH6_FMT = 2'h1;
  localparam logic [1:0] RST_CH6_MODE1 = 2'h2;
  localparam logic [1:0] RST_CH6_MODE2 = 2'h0;

  // ==========================================================================
  // Field positions in the channel 6 control byte
  localparam int SRC_LSB = 6;
  localparam int FMT_LSB = 4;
  localparam int MODE1_LSB = 2;
  localparam int MODE2_LSB = 0;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_PLL1 = 2'h0,
    SRC_PLL2 = 2'h1,
    SRC_PRI_REF = 2'h2,
    SRC_SEC_REF = 2'h3
  } src_sel_t;

  typedef enum logic [1:0] {
    FMT_OFF = 2'h0,
    FMT_AC_DIFF = 2'h1,
    FMT_HCSL = 2'h2,
    FMT_CMOS = 2'h3
  } fmt_t;

  typedef enum logic [1:0] {
    LEG_OFF_HIZ = 2'h0,
    LEG_OFF_LOW = 2'h1,
    LEG_ON_INV = 2'h2,
    LEG_ON_TRUE = 2'h3
  } cmos_leg_t;

  // Gray sequence: idle -> one half taken -> response
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_RESP = 2'b11,
    WR_DATA = 2'b10
  } wr_state_t;

  // Register index from a byte address; low two bits must be zero
  function automatic logic [7:0] addr_index(input logic [7:0] addr);
    return {2'b00, addr[7:2]};
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    logic [7:0] idx;
    idx = addr_index(addr);
    return (addr[1:0] == 2'b00) && (idx >= IDX_CH5_DIV) && (idx <= IDX_STATUS);
  endfunction

  // CMOS leg drive {oe, level} from its mode code and the divided phase
  function automatic logic [1:0] leg_drive(input logic [1:0] mode, input logic phase);
    case (cmos_leg_t'(mode))
      LEG_OFF_HIZ: return 2'b00;
      LEG_OFF_LOW: return 2'b10;
      LEG_ON_INV: return {1'b1, ~phase};
      default: return {1'b1, phase};
    endcase
  endfunction

endpackage

// File: verilog/chan_divider.sv
// Per-channel tick divider: one output pulse per (code + 1) source pulses
module chan_divider #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic [WIDTH-1:0] ratio_code,
  input wire logic bypass,
  output logic div_tick
);

  logic [WIDTH-1:0] count;

  // Compare with >= so a code lowered mid-count cannot strand the counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= 1'b0;
      if (src_tick) begin
        if (bypass || count >= ratio_code) begin
          count <= '0;
          div_tick <= 1'b1;
        end else begin
          count <= count + WIDTH'(1);
        end
      end
    end
  end

endmodule

// File: test/output_channel_divider_ctl_bench.sv
// Self-checking bench for the channel 5 and 6 divider control block
`define CHECK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module output_channel_divider_ctl_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  localparam logic [7:0] ADDR_CH5 = {outdiv_pkg::IDX_CH5_DIV[5:0], 2'b00};
  localparam logic [7:0] ADDR_CTL = {outdiv_pkg::IDX_CH6_CTL[5:0], 2'b00};
  localparam logic [7:0] ADDR_CH6 = {outdiv_pkg::IDX_CH6_DIV[5:0], 2'b00};
  localparam logic [7:0] ADDR_STS = {outdiv_pkg::IDX_STATUS[5:0], 2'b00};
  logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, ticks;
  logic [1:0] bresp, rresp, ch6_format, ch6_tail_code, ch6_load_code;
  logic ch5_src_tick, ch5_src_is_pll, ch5_out_tick, ch6_out_tick, ch6_diff_en;
  logic ch6_p_level, ch6_p_oe, ch6_n_level, ch6_n_oe, pl;
  int error_cnt, total_checks, cycles, cnt5, cnt6;

  output_channel_divider_ctl dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pll1_tick(ticks[0]), .pll2_tick(ticks[1]), .ref_pri_tick(ticks[2]),
    .ref_sec_tick(ticks[3]), .ch5_src_tick(ch5_src_tick), .ch5_src_is_pll(ch5_src_is_pll),
    .ch5_out_tick(ch5_out_tick), .ch6_out_tick(ch6_out_tick), .ch6_diff_en(ch6_diff_en),
    .ch6_format(ch6_format), .ch6_tail_code(ch6_tail_code), .ch6_load_code(ch6_load_code),
    .ch6_p_level(ch6_p_level), .ch6_p_oe(ch6_p_oe), .ch6_n_level(ch6_n_level),
    .ch6_n_oe(ch6_n_oe)
  );

  // ==========================================================================
  // Clock, pulse counters, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (ch5_out_tick === 1'b1) cnt5 <= cnt5 + 1;
    if (ch6_out_tick === 1'b1) cnt6 <= cnt6 + 1;
    cycles <= cycles + 1;
    // Whole run needs about 800 cycles
    if (cycles == 10000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks: address and data offered together, bready held until answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
    bready <= 1'b0;
    `CHECK("bresp", er, bresp)
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    rready <= 1'b0;
    `CHECK("rdata", ed, rdata)
    `CHECK("rresp", er, rresp)
  endtask

  // Source pulses on consecutive cycles, then count what came out
  task automatic run_ticks(input logic [3:0] m, input logic c5, input int n, input int e5,
                           input int e6);
    int b5, b6;
    b5 = cnt5;
    b6 = cnt6;
    repeat (n) begin
      @(posedge sys_clk);
      ticks <= m;
      ch5_src_tick <= c5;
    end
    @(posedge sys_clk);
    ticks <= 4'h0;
    ch5_src_tick <= 1'b0;
    repeat (4) @(posedge sys_clk);
    `CHECK("ch5 pulses", e5, cnt5 - b5)
    `CHECK("ch6 pulses", e6, cnt6 - b6)
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, ch5_src_tick} = 7'h00;
    {awaddr, araddr, wdata, wstrb, ticks, ch5_src_is_pll} = 57'h0;
    {error_cnt, total_checks, cycles, cnt5, cnt6} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    axi_read(ADDR_CH5, 32'h02, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_CTL, 32'h18, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_CH6, 32'h05, outdiv_pkg::RESP_OKAY);
    ch5_src_is_pll <= 1'b1;
    run_ticks(4'h0, 1'b1, 6, 2, 0);
    ch5_src_is_pll <= 1'b0;
    run_ticks(4'h0, 1'b1, 5, 5, 0);
    axi_write(ADDR_CH6, 32'h00, 4'hf, outdiv_pkg::RESP_OKAY);
    run_ticks(4'h1, 1'b0, 5, 0, 5);
    axi_write(ADDR_CH6, 32'h01, 4'hf, outdiv_pkg::RESP_OKAY);
    // Bypassed references must pass every pulse, PLLs every second one
    for (int s = 0; s < 4; s++) begin
      axi_write(ADDR_CTL, {24'h0, s[1:0], 6'h18}, 4'hf, outdiv_pkg::RESP_OKAY);
      run_ticks(4'h1 << s, 1'b0, 4, 0, (s < 2) ? 2 : 4);
      run_ticks(~(4'h1 << s), 1'b0, 4, 0, 0);
    end
    axi_write(ADDR_CTL, 32'h18, 4'hf, outdiv_pkg::RESP_OKAY);
    axi_write(ADDR_CH6, 32'hff, 4'hf, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_CH6, 32'hff, outdiv_pkg::RESP_OKAY);
    run_ticks(4'h1, 1'b0, 512, 0, 2);
    axi_write(ADDR_CH6, 32'h00, 4'hf, outdiv_pkg::RESP_OKAY);
    for (int f = 0; f < 4; f++) begin
      axi_write(ADDR_CTL, {24'h0, 2'h0, f[1:0], 4'hd}, 4'hf, outdiv_pkg::RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      `CHECK("format", f[1:0], ch6_format)
      `CHECK("diff enable", (f == 1 || f == 2), ch6_diff_en)
      `CHECK("tail code", (f != 0) ? 2'h3 : 2'h0, ch6_tail_code)
      `CHECK("load code", (f != 0) ? 2'h1 : 2'h0, ch6_load_code)
      if (f == 0) `CHECK("legs oe", 2'b00, {ch6_p_oe, ch6_n_oe})
      run_ticks(4'h1, 1'b0, 2, 0, (f != 0) ? 2 : 0);
    end
    // CMOS legs: second leg gets the neighbouring code so every code shows on both legs
    for (int m = 0; m < 4; m++) begin
      axi_write(ADDR_CTL, {24'h0, 4'h3, m[1:0], m[1:0] ^ 2'h1}, 4'hf,
                outdiv_pkg::RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      `CHECK("p oe", m != 0, ch6_p_oe)
      `CHECK("n oe", m != 1, ch6_n_oe)
      if (m < 2) `CHECK("low leg", 1'b0, m[0] ? ch6_p_level : ch6_n_level)
      else begin
        `CHECK("leg polarity", ~ch6_n_level, ch6_p_level)
        pl = ch6_p_level;
        run_ticks(4'h1, 1'b0, 1, 0, 1);
        `CHECK("leg follows", ~pl, ch6_p_level)
      end
    end
    // Refused and unmapped accesses leave the registers alone
    axi_write(ADDR_CH5, 32'h77, 4'he, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_CH5, 32'h02, outdiv_pkg::RESP_OKAY);
    axi_write(8'hb0, 32'h11, 4'hf, outdiv_pkg::RESP_SLVERR);
    axi_write(ADDR_CH5 + 8'h01, 32'h11, 4'hf, outdiv_pkg::RESP_SLVERR);
    axi_read(8'hb0, 32'h00, outdiv_pkg::RESP_SLVERR);
    axi_read(ADDR_CH5, 32'h02, outdiv_pkg::RESP_OKAY);
    // Mid-run reset must undo the CMOS setup and the channel 6 code written above
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    axi_read(ADDR_CTL, 32'h18, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_CH6, 32'h05, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_STS, 32'h03, outdiv_pkg::RESP_OKAY);
    axi_write(ADDR_STS, 32'h00, 4'hf, outdiv_pkg::RESP_OKAY);
    axi_read(ADDR_STS, 32'h03, outdiv_pkg::RESP_OKAY);
    end_of_test();
  end
endmodule
